// ===== pcm_codec_pkg.sv
// Purpose: shared constants and carriers for the PCM coding and framing block
// Assumes: 10 MHz system clock, bit clock sampled as a plain input
// Notes: register offsets are the printed byte addresses of the control port
package pcm_codec_pkg;
    localparam logic [7:0] GAIN_ONE_OFS = 8'h00;
    localparam logic [7:0] GAIN_TWO_OFS = 8'h01;
    localparam logic [7:0] CODING_OFS = 8'h04;
    localparam logic [7:0] GAIN_ONE_RST = 8'h00;
    localparam logic [7:0] GAIN_TWO_RST = 8'h00;
    localparam logic [7:0] CODING_RST = 8'h00;
    // gain_control_one fields
    localparam int TXG_LSB = 0;
    localparam int RXG_LSB = 3;
    // gain_control_two fields
    localparam int STG_LSB = 0;
    localparam int STEN_BIT = 3;
    // coding_control fields
    localparam int ALAW_BIT = 0;
    localparam int SMAG_BIT = 1;
    localparam int DEN_BIT = 2;
    localparam int BUSMODE_BIT = 3;
    localparam int SLOT_BITS = 8;
    localparam int DELAY_SLOTS = 4;
    localparam logic [7:0] ADI_MASK = 8'h55;
    localparam logic [7:0] MU_INV_MASK = 8'h7F;

    typedef struct packed {
        logic [2:0] tx_filter_gain;
        logic [2:0] rx_filter_gain;
        logic [2:0] sidetone_gain;
        logic sidetone_en;
        logic alaw;
        logic code_format_select;
    } coding_cfg_s;

    typedef enum logic [1:0] {
        CODE_SMAG = 2'b00,
        CODE_MU = 2'b01,
        CODE_ALAW = 2'b11
    } code_law_e;

    // sign-magnitude to line code and back (both maps are self-inverse)
    function automatic logic [7:0] line_code(input logic [7:0] sm, input code_law_e law);
        logic [7:0] r;
        r = sm;
        unique case (law)
            CODE_SMAG: r = sm;
            CODE_MU: r = sm ^ MU_INV_MASK;
            CODE_ALAW: r = sm ^ ADI_MASK;
        endcase
        return r;
    endfunction
endpackage

// ===== pcm_bit_sync.sv
// Purpose: two-stage synchroniser for pins from outside the system clock
// Assumes: inputs are slow against CLK_SYS_I
// Notes: first stage read only by the second
`timescale 1ns/1ns
module pcm_bit_sync (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] async_i,
    output logic [3:0] sync_o
);
    logic [3:0] meta_r;
    logic [3:0] meta_nxt;
    logic [3:0] sync_nxt;
    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= 4'h0;
            sync_o <= 4'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_o <= sync_nxt;
        end
    end
endmodule

// ===== pcm_coding_framing_control.sv
// Purpose: digital side of a voice codec: serial PCM slot, delayed frame, coding control
// Assumes: bit clock and frame strobe come from the transceiver, sampled at 10 MHz
// Notes: samples cross to/from the converter as sign-magnitude words
`timescale 1ns/1ns
module pcm_coding_framing_control
    import pcm_codec_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire logic POWER_UP_RESET_N_I,
    input wire logic DEVICE_CLOCK_INPUT_I,
    input wire logic FRAME_STROBE_IN_I,
    input wire logic DIN_I,
    input wire logic LAW_PIN_I,
    output logic DOUT_O,
    output logic DOUT_OE_N_O,
    output logic DELAYED_FRAME_OUT_O,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [7:0] TX_SAMPLE_I,
    output logic [7:0] RX_SAMPLE_O,
    output logic RX_VALID_O,
    output logic TX_TAKEN_O,
    output coding_cfg_s CFG_O
);
    logic [3:0] sync_w;
    logic bclk_s, strb_s, din_s, law_s;
    pcm_bit_sync u_sync (
        .clk_i(CLK_SYS_I),
        .srst_i(SRST_I),
        .async_i({DEVICE_CLOCK_INPUT_I, FRAME_STROBE_IN_I, DIN_I, LAW_PIN_I}),
        .sync_o(sync_w)
    );
    assign {bclk_s, strb_s, din_s, law_s} = sync_w;

    // power-up reset pin is asynchronous, so synchronise it too
    logic [1:0] pwr_r, pwr_nxt;
    logic rst_all;
    always_comb pwr_nxt = {pwr_r[0], POWER_UP_RESET_N_I};
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) pwr_r <= 2'b00;
        else pwr_r <= pwr_nxt;
    end
    assign rst_all = SRST_I | ~pwr_r[1];

    // registers
    logic [7:0] g1_r, g1_nxt, g2_r, g2_nxt, cc_r, cc_nxt;
    always_comb begin
        g1_nxt = g1_r;
        g2_nxt = g2_r;
        cc_nxt = cc_r;
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                GAIN_ONE_OFS: g1_nxt = REG_WDATA_I;
                GAIN_TWO_OFS: g2_nxt = REG_WDATA_I;
                CODING_OFS: cc_nxt = REG_WDATA_I;
                default: ;
            endcase
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (rst_all) begin
            g1_r <= GAIN_ONE_RST;
            g2_r <= GAIN_TWO_RST;
            cc_r <= CODING_RST;
        end else begin
            g1_r <= g1_nxt;
            g2_r <= g2_nxt;
            cc_r <= cc_nxt;
        end
    end
    always_comb begin
        unique case (REG_ADDR_I)
            GAIN_ONE_OFS: REG_RDATA_O = g1_r;
            GAIN_TWO_OFS: REG_RDATA_O = g2_r;
            CODING_OFS: REG_RDATA_O = cc_r;
            default: REG_RDATA_O = 8'h00;
        endcase
    end

    logic alaw_sel, bus_mode;
    code_law_e law;
    assign alaw_sel = cc_r[ALAW_BIT] | (~cc_r[DEN_BIT] & law_s);
    assign bus_mode = cc_r[BUSMODE_BIT];
    always_comb begin
        if (cc_r[SMAG_BIT]) law = CODE_SMAG;
        else if (alaw_sel) law = CODE_ALAW;
        else law = CODE_MU;
    end
    always_comb begin
        CFG_O.tx_filter_gain = g1_r[TXG_LSB +: 3];
        CFG_O.rx_filter_gain = g1_r[RXG_LSB +: 3];
        CFG_O.sidetone_gain = g2_r[STG_LSB +: 3];
        CFG_O.sidetone_en = g2_r[STEN_BIT];
        CFG_O.alaw = alaw_sel;
        CFG_O.code_format_select = cc_r[SMAG_BIT];
    end

    // edge detection on synchronised pins
    logic bclk_d, strb_d;
    logic rise, fall, strb_rise, strb_fall;
    always_ff @(posedge CLK_SYS_I) begin
        if (rst_all) begin
            bclk_d <= 1'b0;
            strb_d <= 1'b0;
        end else begin
            bclk_d <= bclk_s;
            strb_d <= strb_s;
        end
    end
    assign rise = bclk_s & ~bclk_d;
    assign fall = ~bclk_s & bclk_d;
    assign strb_rise = strb_s & ~strb_d;
    assign strb_fall = ~strb_s & strb_d;

    // serial slot: one sample per frame each way
    logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, rx_r, rx_nxt;
    logic [3:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
    logic slot_r, slot_nxt, dout_r, dout_nxt, rxv_r, rxv_nxt, taken;
    always_comb begin
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        rx_nxt = rx_r;
        tcnt_nxt = tcnt_r;
        rcnt_nxt = rcnt_r;
        slot_nxt = slot_r;
        dout_nxt = dout_r;
        rxv_nxt = 1'b0;
        taken = 1'b0;
        if (strb_rise) begin
            tx_sh_nxt = line_code(TX_SAMPLE_I, law);
            tcnt_nxt = 4'h0;
            rcnt_nxt = 4'h0;
            slot_nxt = 1'b1;
            taken = 1'b1;
        end else if (slot_r) begin
            if (rise && tcnt_r < 4'(SLOT_BITS)) begin
                dout_nxt = tx_sh_r[7];
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
                tcnt_nxt = tcnt_r + 4'h1;
            end
            if (fall && tcnt_r != 4'h0 && rcnt_r < 4'(SLOT_BITS)) begin
                rx_sh_nxt = {rx_sh_r[6:0], din_s};
                rcnt_nxt = rcnt_r + 4'h1;
                if (rcnt_r == 4'(SLOT_BITS - 1)) begin
                    rx_nxt = line_code({rx_sh_r[6:0], din_s}, law);
                    rxv_nxt = 1'b1;
                    slot_nxt = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (rst_all) begin
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            rx_r <= 8'h00;
            tcnt_r <= 4'h0;
            rcnt_r <= 4'h0;
            slot_r <= 1'b0;
            dout_r <= 1'b0;
            rxv_r <= 1'b0;
        end else begin
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_r <= rx_nxt;
            tcnt_r <= tcnt_nxt;
            rcnt_r <= rcnt_nxt;
            slot_r <= slot_nxt;
            dout_r <= dout_nxt;
            rxv_r <= rxv_nxt;
        end
    end
    assign DOUT_O = dout_r;
    assign DOUT_OE_N_O = ~(slot_r & tcnt_r != 4'h0);
    assign RX_SAMPLE_O = rx_r;
    assign RX_VALID_O = rxv_r;
    assign TX_TAKEN_O = taken;

    // delayed frame output for cascading
    typedef enum logic [1:0] {DF_IDLE = 2'b00, DF_WAIT = 2'b01, DF_OUT = 2'b11} dframe_e;
    dframe_e df_r, df_nxt;
    logic [5:0] dcnt_r, dcnt_nxt;
    logic dfo_r, dfo_nxt;
    always_comb begin
        df_nxt = df_r;
        dcnt_nxt = dcnt_r;
        dfo_nxt = dfo_r;
        unique case (df_r)
            DF_IDLE: begin
                if (!bus_mode && strb_fall) begin
                    df_nxt = DF_OUT;
                    dfo_nxt = 1'b1;
                    dcnt_nxt = 6'(SLOT_BITS);
                end else if (bus_mode && strb_rise) begin
                    df_nxt = DF_WAIT;
                    dcnt_nxt = 6'(SLOT_BITS * DELAY_SLOTS);
                end
            end
            DF_WAIT: begin
                if (fall) dcnt_nxt = dcnt_r - 6'h01;
                if (fall && dcnt_r == 6'h01) begin
                    df_nxt = DF_OUT;
                    dfo_nxt = 1'b1;
                    dcnt_nxt = 6'h01;
                end
            end
            DF_OUT: begin
                if (fall) dcnt_nxt = dcnt_r - 6'h01;
                if (fall && dcnt_r == 6'h01) begin
                    df_nxt = DF_IDLE;
                    dfo_nxt = 1'b0;
                end
            end
            default: begin
                df_nxt = DF_IDLE;
                dfo_nxt = 1'b0;
            end
        endcase
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (rst_all) begin
            df_r <= DF_IDLE;
            dcnt_r <= 6'h00;
            dfo_r <= 1'b0;
        end else begin
            df_r <= df_nxt;
            dcnt_r <= dcnt_nxt;
            dfo_r <= dfo_nxt;
        end
    end
    assign DELAYED_FRAME_OUT_O = dfo_r;

    a_reset_defaults: assert property (@(posedge CLK_SYS_I) $fell(rst_all) |->
        g2_r[STEN_BIT] == 1'b0 && g1_r == 8'h00 && !cc_r[ALAW_BIT])
        else $error("defaults wrong after reset");
    a_law_or: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        cc_r[ALAW_BIT] |-> CFG_O.alaw)
        else $error("register A-law ignored");
    a_pin_law: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (!cc_r[DEN_BIT] && law_s) |-> CFG_O.alaw)
        else $error("law pin ignored");
    a_sidetone_map: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        CFG_O.sidetone_en == g2_r[STEN_BIT])
        else $error("sidetone enable mismatch");
    a_gain_write: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (REG_WR_I && REG_ADDR_I == GAIN_ONE_OFS) |=> g1_r == $past(REG_WDATA_I))
        else $error("gain register not written");
    a_stg_write: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (REG_WR_I && REG_ADDR_I == GAIN_TWO_OFS) |=>
        CFG_O.sidetone_gain == $past(REG_WDATA_I[2:0]))
        else $error("sidetone gain not written");
    a_coding_write: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (REG_WR_I && REG_ADDR_I == CODING_OFS) |=> cc_r == $past(REG_WDATA_I))
        else $error("coding register not written");
    a_mu_zero: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (strb_rise && law == CODE_MU && TX_SAMPLE_I == 8'h00) |=> tx_sh_r == 8'h7F)
        else $error("mu-law quiet code wrong");
    a_alaw_fs: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (strb_rise && law == CODE_ALAW && TX_SAMPLE_I == 8'hFF) |=> tx_sh_r == 8'hAA)
        else $error("A-law full scale wrong");
    a_smag_pass: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (strb_rise && law == CODE_SMAG) |=> tx_sh_r == $past(TX_SAMPLE_I))
        else $error("sign-magnitude altered");
    a_slot_drive: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        !slot_r |-> DOUT_OE_N_O)
        else $error("driving outside slot");
    a_strobe_delay: assert property (@(posedge CLK_SYS_I) disable iff (rst_all)
        (!bus_mode && strb_fall && df_r == DF_IDLE) |=> DELAYED_FRAME_OUT_O)
        else $error("delayed strobe missing");
endmodule

// ===== pcm_link_partner.sv
// Purpose: transceiver model for the strobed serial PCM link
// Assumes: bit clock runs free at 800 ns; edges fall on system clock falling edges
// Notes: data line driven to the inverse of its last bit outside the slot
`timescale 1ns/1ns
module pcm_link_partner (
    input wire logic dout_i,
    input wire logic dout_oe_n_i,
    output logic bclk_o,
    output logic strobe_o,
    output logic din_o,
    output logic [7:0] got_o
);
    event done;
    initial begin
        bclk_o = 1'b0;
        strobe_o = 1'b0;
        din_o = 1'b0;
        got_o = 8'h00;
    end
    always #400 bclk_o = ~bclk_o;
    // one 8-bit slot: msb first, driven after rise, device data taken on fall
    task automatic frame(input logic [7:0] tx);
        @(negedge bclk_o);
        #100 strobe_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            @(posedge bclk_o);
            #100 din_o = tx[i];
            @(negedge bclk_o);
            // released line reads as the inverse of what the device last drove
            got_o[i] = dout_oe_n_i ? ~dout_i : dout_i;
        end
        #200 strobe_o = 1'b0;
        din_o = ~din_o;
        ->done;
    endtask
    // single frame pulse one bit period wide
    task automatic pulse();
        @(negedge bclk_o);
        #100 strobe_o = 1'b1;
        @(negedge bclk_o);
        #100 strobe_o = 1'b0;
    endtask
endmodule

// ===== pcm_coding_framing_control_tb.sv
// Purpose: self-checking bench for the PCM coding and framing block
// Assumes: 10 MHz system clock, free-running 800 ns bit clock from the partner
// Notes: line codes and received samples are checked through expectation queues
`timescale 1ns/1ns
module pcm_coding_framing_control_tb;
    import pcm_codec_pkg::*;
    logic clk_sys, srst, pwr_n, wr, law_pin, bclk, strobe, din, dout, dout_oe_n;
    logic dly, rx_valid, tx_taken, framed;
    logic [7:0] addr, wdata, rdata, tx_sample, rx_sample, got, r;
    coding_cfg_s cfg;
    int err_count, compares, taken_count, n;
    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];
    logic [7:0] cc[6] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h03};
    logic [7:0] mask[6] = '{8'h7F, 8'h55, 8'h55, 8'h00, 8'h7F, 8'h00};
    logic pin[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    pcm_coding_framing_control i_dut (
        .CLK_SYS_I(clk_sys), .SRST_I(srst), .POWER_UP_RESET_N_I(pwr_n),
        .DEVICE_CLOCK_INPUT_I(bclk), .FRAME_STROBE_IN_I(strobe), .DIN_I(din),
        .LAW_PIN_I(law_pin), .DOUT_O(dout), .DOUT_OE_N_O(dout_oe_n),
        .DELAYED_FRAME_OUT_O(dly), .REG_WR_I(wr), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .TX_SAMPLE_I(tx_sample),
        .RX_SAMPLE_O(rx_sample), .RX_VALID_O(rx_valid), .TX_TAKEN_O(tx_taken),
        .CFG_O(cfg)
    );
    pcm_link_partner i_link (.dout_i(dout), .dout_oe_n_i(dout_oe_n), .bclk_o(bclk),
        .strobe_o(strobe), .din_o(din), .got_o(got));

    always #50 clk_sys = ~clk_sys;

    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        chk8({7'h00, g}, {7'h00, e}, m);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_sys);
        wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        addr = a;
        #10 chk8(rdata, e, "register read");
    endtask
    // counts cycles until the delayed output rises, bounded
    task automatic wait_dly(input int bound, output int k);
        k = 0;
        while (dly !== 1'b1) begin
            @(negedge clk_sys);
            k++;
            if (k > bound) begin
                err_count++;
                $display("mismatch at %0t: delayed frame never rose", $time);
                results();
            end
        end
    endtask

    always @(negedge clk_sys) begin
        if (tx_taken === 1'b1) taken_count++;
        if (rx_valid === 1'b1 && !framed) begin
            if (rx_q.size() == 0) chk1(1'b1, 1'b0, "unexpected rx sample");
            else chk8(rx_sample, rx_q.pop_front(), "rx sample");
        end
    end
    always @(i_link.done) begin
        if (tx_q.size() == 0) chk1(1'b1, 1'b0, "unexpected slot");
        else chk8(got, tx_q.pop_front(), "line code");
    end

    initial begin
        #5000000;
        err_count++;
        $display("mismatch at %0t: run timed out", $time);
        results();
    end

    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        pwr_n = 1'b0;
        wr = 1'b0;
        law_pin = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        tx_sample = 8'h00;
        framed = 1'b0;
        err_count = 0;
        compares = 0;
        taken_count = 0;
        void'($urandom(19));
        repeat (4) @(negedge clk_sys);
        pwr_n = 1'b1;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        reg_rd(GAIN_ONE_OFS, GAIN_ONE_RST);
        reg_rd(GAIN_TWO_OFS, GAIN_TWO_RST);
        reg_rd(CODING_OFS, CODING_RST);
        r = 8'($urandom);
        reg_wr(GAIN_ONE_OFS, r);
        reg_rd(GAIN_ONE_OFS, r);
        chk8({2'b00, cfg.tx_filter_gain, cfg.rx_filter_gain},
            {2'b00, r[2:0], r[5:3]}, "gain1");
        r = 8'($urandom);
        reg_wr(GAIN_TWO_OFS, r);
        reg_rd(GAIN_TWO_OFS, r);
        chk8({4'h0, cfg.sidetone_en, cfg.sidetone_gain}, {4'h0, r[3:0]}, "gain2");
        reg_wr(CODING_OFS, 8'h03);
        reg_rd(CODING_OFS, 8'h03);
        reg_wr(8'h02, 8'hA5);
        reg_rd(8'h02, 8'h00);
        @(negedge clk_sys);
        pwr_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        pwr_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        reg_rd(GAIN_TWO_OFS, 8'h00);
        reg_rd(CODING_OFS, 8'h00);
        chk1(|cfg, 1'b0, "config after power-up reset");
        $display("test registers done");
        for (int m = 0; m < 6; m++) begin
            reg_wr(CODING_OFS, cc[m]);
            law_pin = pin[m];
            // quiet code under mu-law and full scale under A-law reach the code assertions
            if (m == 0) begin
                tx_sample = 8'h00;
            end else if (m == 1) begin
                tx_sample = 8'hFF;
            end else begin
                tx_sample = 8'($urandom);
            end
            r = 8'($urandom);
            tx_q.push_back(tx_sample ^ mask[m]);
            rx_q.push_back(r ^ mask[m]);
            i_link.frame(r);
            wait_dly(8, n);
            chk1(dout_oe_n, 1'b1, "output enable after slot");
            chk1(cfg.alaw, cc[m][0] | (~cc[m][2] & pin[m]), "law select");
            // eighth bit-clock fall after the strobe lands between the two looks
            repeat (57) @(negedge clk_sys);
            chk1(dly, 1'b1, "delayed strobe held");
            repeat (7) @(negedge clk_sys);
            chk1(dly, 1'b0, "delayed strobe ended");
            repeat (1118) @(negedge clk_sys);
        end
        chk8(8'(taken_count), 8'h06, "samples taken");
        chk1(rx_q.size() == 0 && tx_q.size() == 0, 1'b1, "all slots seen");
        $display("test coding modes done");
        framed = 1'b1;
        reg_wr(CODING_OFS, 8'h08);
        repeat (40) @(negedge clk_sys);
        i_link.pulse();
        wait_dly(400, n);
        // 700 ns to first fall, then one bit per 800 ns; 8 cycles already spent in pulse
        r = 8'((700 + (DELAY_SLOTS * SLOT_BITS - 1) * 800) / 100 - 8);
        chk1(n >= int'(r) - 3 && n <= int'(r) + 6, 1'b1, "frame pulse delay");
        // pulse stands for one bit period, ended by the next bit-clock fall
        repeat (4) @(negedge clk_sys);
        chk1(dly, 1'b1, "frame pulse held");
        repeat (4) @(negedge clk_sys);
        chk1(dly, 1'b0, "frame pulse one bit wide");
        $display("test framed delay done");
        results();
    end
endmodule
